// file: shared/gtpb_params.svh
`ifndef GTPB_PARAMS_SVH
`define GTPB_PARAMS_SVH

// Register word offsets (byte address bits 7:2)
`define GTPB_ADR_CTRL    6'h00
`define GTPB_ADR_SAMPLER 6'h01
`define GTPB_ADR_BINDING 6'h02
`define GTPB_ADR_SCRATCH 6'h03
`define GTPB_ADR_SEMA    6'h04
`define GTPB_ADR_LENGTH  6'h05
`define GTPB_ADR_STATUS  6'h06

// Reset values
`define GTPB_CTRL_RST    32'h0000_0000
`define GTPB_PTR_RST     32'h0000_0000
`define GTPB_LENGTH_RST  32'h0000_0000

// Control fields
`define GTPB_CTRL_MODE_HI 1
`define GTPB_CTRL_MODE_LO 0
`define GTPB_CTRL_PRIM    2
`define GTPB_CTRL_HND     3
`define GTPB_CTRL_DISC    4
`define GTPB_CTRL_HINT    5

// Length fields, in 256-bit registers
`define GTPB_LEN_CON_HI  5
`define GTPB_LEN_CON_LO  0
`define GTPB_LEN_VTX_HI  13
`define GTPB_LEN_VTX_LO  8

// Header encodings
`define GTPB_TOPO_UNDEF   6'h00
`define GTPB_SCR_SIZE_MAX 4'hB
`define GTPB_RET_MASK     16'hEFFF

`endif

// file: shared/gtpb_pkg.sv
package gtpb_pkg;

   typedef enum logic [1:0] {
      MODE_SINGLE    = 2'h0,
      MODE_DUAL_INST = 2'h1,
      MODE_DUAL_OBJ  = 2'h2,
      MODE_RSVD      = 2'h3
   } gtpb_mode_e;

   // Gray along idle, header, prim, handles, constants, vertices
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR  = 3'b001,
      ST_PRIM = 3'b011,
      ST_HND  = 3'b010,
      ST_CON  = 3'b110,
      ST_VTX  = 3'b111
   } gtpb_state_e;

   typedef struct packed {
      logic [15:0] ret0;
      logic [15:0] ret1;
      logic [4:0]  inst0;
      logic [4:0]  inst1;
      logic [5:0]  topo;
      logic [7:0]  sema_idx;
      logic [6:0]  tag;
      logic        deref;
      logic [31:0] prim0;
      logic [31:0] prim1;
      logic [5:0]  icp_cnt;
   } gtpb_spawn_s;

   typedef logic [31:0][31:0] gtpb_hnd_t;

   typedef struct packed {
      logic [255:0] data;
      logic         last;
   } gtpb_beat_s;

endpackage : gtpb_pkg

// file: src/gtpb_payload_builder.sv
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "gtpb_params.svh"

// Functional notes
// RL1: Dword0 low half: lower-channel return offset
// RL2: Dword1 low half: upper-channel return offset
// RL3: Instance numbers at 31:27, invalid dual-object
// RL4: Dword2 12:0 carries semaphore offset
// RL5: Topology type; undefined when adjacency discarded
// RL6: Dword2 bit 22 copies hint bit
// RL7: Dword2 31:24 semaphore dword index
// RL8: Dword5 31:10 scratch space offset
// RL9: Thread tag 0-127; frees resources on completion
// RL10: Dword4 31:5 binding table pointer
// RL11: Dword3 31:5 sampler state pointer
// RL12: Dword3 3:0 scratch size, 0 to 11
// RL13: Dword6 23:0 unique thread identifier
// RL14: Dword6 dereference flag for handle return
// RL15: Primitive register only when enabled; R1.0
// RL16: R1.4 object 1 primitive; rest zero
// RL17: Handle dword: identifier high, handle low
// RL18: Extra handle register per eight points; the code adds one per four points in dual-object mode
// RL19: Dual-object handles: object0 low, object1 high
// RL20: Header, prims, handles, constants, vertex data
// RL21: Dual-object vertex data split into halves
// RL22: Constants follow header, sized by state; the code puts enabled prim and handle registers in between
module gtpb_payload_builder (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 spawn_valid_i,
   input  wire gtpb_pkg::gtpb_spawn_s spawn_i,
   input  wire gtpb_pkg::gtpb_hnd_t  hnd_i,
   output logic                      spawn_ready_o,
   input  wire logic                 done_valid_i,
   input  wire logic [6:0]           done_tag_i,
   input  wire logic                 dat_valid_i,
   input  wire logic [255:0]         dat_i,
   output logic                      dat_ready_o,
   output gtpb_pkg::gtpb_beat_s      out_o,
   output logic                      out_valid_o,
   input  wire logic                 out_ready_i
);
   import gtpb_pkg::*;

   // ==========================================================
   // Register file
   // ==========================================================
   logic [31:0] ctrl_ff;
   logic [31:0] smp_ff;
   logic [31:0] bnd_ff;
   logic [31:0] scr_ff;
   logic [31:0] sem_ff;
   logic [31:0] len_ff;
   logic [31:0] rdat_ff;
   logic        ack_ff;
   logic        wb_req;
   logic        wb_wr;
   logic [5:0]  wadr;
   logic [23:0] tid_ff;
   logic [127:0] live_ff;
   gtpb_state_e st_ff;

   assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wb_wr  = wb_req && wb_we_i;
   assign wadr   = wb_adr_i[7:2];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (wb_sel_i[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      return r;
   endfunction : merge

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_ff <= `GTPB_CTRL_RST;
         smp_ff  <= `GTPB_PTR_RST;
         bnd_ff  <= `GTPB_PTR_RST;
         scr_ff  <= `GTPB_PTR_RST;
         sem_ff  <= `GTPB_PTR_RST;
         len_ff  <= `GTPB_LENGTH_RST;
      end
      else if (ce_i && wb_wr)
      begin
         if (wadr == `GTPB_ADR_CTRL)
            ctrl_ff <= merge(ctrl_ff, wb_dat_i);
         else if (wadr == `GTPB_ADR_SAMPLER)
            smp_ff <= merge(smp_ff, wb_dat_i);
         else if (wadr == `GTPB_ADR_BINDING)
            bnd_ff <= merge(bnd_ff, wb_dat_i);
         else if (wadr == `GTPB_ADR_SCRATCH)
            scr_ff <= merge(scr_ff, wb_dat_i);
         else if (wadr == `GTPB_ADR_SEMA)
            sem_ff <= merge(sem_ff, wb_dat_i);
         else if (wadr == `GTPB_ADR_LENGTH)
            len_ff <= merge(len_ff, wb_dat_i);
      end
   end

   // Unmapped reads answer zero; writes there are dropped
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         ack_ff <= wb_req;
         if (wadr == `GTPB_ADR_CTRL)
            rdat_ff <= ctrl_ff;
         else if (wadr == `GTPB_ADR_SAMPLER)
            rdat_ff <= smp_ff;
         else if (wadr == `GTPB_ADR_BINDING)
            rdat_ff <= bnd_ff;
         else if (wadr == `GTPB_ADR_SCRATCH)
            rdat_ff <= scr_ff;
         else if (wadr == `GTPB_ADR_SEMA)
            rdat_ff <= sem_ff;
         else if (wadr == `GTPB_ADR_LENGTH)
            rdat_ff <= len_ff;
         else if (wadr == `GTPB_ADR_STATUS)
            rdat_ff <= {tid_ff, 6'h00, |live_ff, st_ff != ST_IDLE};
         else
            rdat_ff <= 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   // ==========================================================
   // Sequencing
   // ==========================================================
   gtpb_spawn_s sp_ff;
   gtpb_hnd_t   hnd_ff;
   gtpb_beat_s  out_ff;
   logic        ov_ff;
   logic        sp_rdy_ff;
   logic        dat_rdy_ff;
   logic        half_ff;
   logic [127:0] hold_ff;
   logic [10:0] cnt_ff;
   logic        dual_obj;
   logic        inc_prim;
   logic        inc_hnd;
   logic [5:0]  n_hnd;
   logic [5:0]  n_con;
   logic [10:0] n_vtx;
   logic [10:0] plen;
   logic        free;
   logic        gen;
   logic        take;
   logic        emit;
   logic        fin;
   logic        accept;
   gtpb_state_e ph_next;
   logic [7:0][31:0] hdr;
   logic [7:0][31:0] prim;
   logic [7:0][31:0] hreg;
   logic [255:0] beat_d;

   assign dual_obj = gtpb_mode_e'(ctrl_ff[`GTPB_CTRL_MODE_HI:`GTPB_CTRL_MODE_LO]) == MODE_DUAL_OBJ;
   assign inc_prim = ctrl_ff[`GTPB_CTRL_PRIM];
   assign inc_hnd  = ctrl_ff[`GTPB_CTRL_HND];
   // RL18 extra handle registers
   assign n_hnd = dual_obj ? 6'((sp_ff.icp_cnt + 6'd3) >> 2) : 6'((sp_ff.icp_cnt + 6'd7) >> 3);
   // RL22 constant length from state
   assign n_con = len_ff[`GTPB_LEN_CON_HI:`GTPB_LEN_CON_LO];
   assign n_vtx = 11'(sp_ff.icp_cnt * len_ff[`GTPB_LEN_VTX_HI:`GTPB_LEN_VTX_LO]);

   // RL20 fixed section order, empty sections skipped
   function automatic gtpb_state_e after(input gtpb_state_e s);
      gtpb_state_e r;
      r = ST_IDLE;
      if (s == ST_HDR && inc_prim)
         r = ST_PRIM;
      else if ((s == ST_HDR || s == ST_PRIM) && inc_hnd && n_hnd != 6'd0)
         r = ST_HND;
      else if (s != ST_CON && s != ST_VTX && n_con != 6'd0)
         r = ST_CON;
      else if (s != ST_VTX && n_vtx != 11'd0)
         r = ST_VTX;
      return r;
   endfunction : after

   always_comb
   begin
      plen = 11'd1;
      if (st_ff == ST_HND)
         plen = {5'd0, n_hnd};
      else if (st_ff == ST_CON)
         plen = {5'd0, n_con};
      else if (st_ff == ST_VTX)
         plen = n_vtx;
   end

   assign ph_next = after(st_ff);
   assign free    = !ov_ff || out_ready_i;
   assign gen     = (st_ff == ST_HDR || st_ff == ST_PRIM || st_ff == ST_HND) && free;
   assign take    = dat_valid_i && dat_rdy_ff;
   // RL21 first half of a dual-object vertex register is only held
   assign emit    = gen || (take && !(st_ff == ST_VTX && dual_obj && !half_ff));
   assign fin     = emit && (cnt_ff == plen - 11'd1);
   // RL9 a tag still in use is not handed out again
   assign accept  = st_ff == ST_IDLE && spawn_valid_i && sp_rdy_ff && !live_ff[spawn_i.tag];

   // ==========================================================
   // Header and optional registers
   // ==========================================================
   always_comb
   begin
      hdr = '0;
      // RL1 lower-channel offset
      hdr[0][15:0]  = spawn_ret(sp_ff.ret0);
      // RL2 upper-channel offset
      hdr[1][15:0]  = spawn_ret(sp_ff.ret1);
      // RL3 instance numbers, void in dual-object
      hdr[0][31:27] = dual_obj ? 5'd0 : sp_ff.inst0;
      hdr[1][31:27] = dual_obj ? 5'd0 : sp_ff.inst1;
      // RL4 semaphore offset
      hdr[2][12:0]  = sem_ff[12:0];
      // RL5 topology type
      hdr[2][21:16] = ctrl_ff[`GTPB_CTRL_DISC] ? `GTPB_TOPO_UNDEF : sp_ff.topo;
      // RL6 hint copy
      hdr[2][22]    = ctrl_ff[`GTPB_CTRL_HINT];
      // RL7 semaphore index
      hdr[2][31:24] = sp_ff.sema_idx;
      // RL11 sampler pointer
      hdr[3][31:5]  = smp_ff[31:5];
      // RL12 scratch size, clamped to 2MB
      hdr[3][3:0]   = (scr_ff[3:0] > `GTPB_SCR_SIZE_MAX) ? `GTPB_SCR_SIZE_MAX : scr_ff[3:0];
      // RL10 binding table pointer
      hdr[4][31:5]  = bnd_ff[31:5];
      // RL8 scratch offset
      hdr[5][31:10] = scr_ff[31:10];
      // RL9 thread tag
      hdr[5][8:0]   = {2'b00, sp_ff.tag};
      // RL13 thread identifier
      hdr[6][23:0]  = tid_ff;
      // RL14 dereference flag
      hdr[6][31]    = sp_ff.deref;
   end

   function automatic logic [15:0] spawn_ret(input logic [15:0] v);
      return v & `GTPB_RET_MASK;
   endfunction : spawn_ret

   always_comb
   begin
      prim = '0;
      // RL15 object 0 primitive
      prim[0] = sp_ff.prim0;
      // RL16 object 1 primitive, dual-object only
      prim[4] = dual_obj ? sp_ff.prim1 : 32'h0000_0000;
   end

   for (genvar k = 0; k < 8; k++)
   begin : g_hnd
      localparam logic [2:0] KK = 3'(k);
      // RL17 RL19 handle dword selection per mode
      assign hreg[k] = dual_obj ? hnd_ff[{KK[2], cnt_ff[1:0], KK[1:0]}] : hnd_ff[{cnt_ff[1:0], KK}];
   end

   always_comb
   begin
      beat_d = dat_i;
      case (st_ff)
         ST_HDR:  beat_d = hdr;
         ST_PRIM: beat_d = prim;
         ST_HND:  beat_d = hreg;
         ST_VTX:  beat_d = dual_obj ? {dat_i[127:0], hold_ff} : dat_i;
         default: beat_d = dat_i;
      endcase
   end

   // ==========================================================
   // State, counters and stream ports
   // ==========================================================
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff  <= ST_IDLE;
         cnt_ff <= 11'd0;
      end
      else if (ce_i)
      begin
         if (accept)
            st_ff <= ST_HDR;
         else if (fin)
            st_ff <= ph_next;
         if (accept || fin)
            cnt_ff <= 11'd0;
         else if (emit)
            cnt_ff <= cnt_ff + 11'd1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sp_ff  <= '0;
         hnd_ff <= '0;
      end
      else if (ce_i && accept)
      begin
         sp_ff  <= spawn_i;
         hnd_ff <= hnd_i;
      end
   end

   // Ready is registered, so data moves at most every other cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sp_rdy_ff  <= 1'b0;
         dat_rdy_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         sp_rdy_ff  <= st_ff == ST_IDLE && !accept;
         dat_rdy_ff <= (st_ff == ST_CON || st_ff == ST_VTX) && !take && !fin && free;
      end
   end

   // RL21 lower half object 0, upper half object 1
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         half_ff <= 1'b0;
         hold_ff <= '0;
      end
      else if (ce_i)
      begin
         if (accept)
            half_ff <= 1'b0;
         else if (take && st_ff == ST_VTX && dual_obj)
            half_ff <= !half_ff;
         if (take && !half_ff)
            hold_ff <= dat_i[127:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         out_ff <= '0;
         ov_ff  <= 1'b0;
      end
      else if (ce_i)
      begin
         if (emit)
         begin
            out_ff.data <= beat_d;
            out_ff.last <= fin && ph_next == ST_IDLE;
            ov_ff       <= 1'b1;
         end
         else if (out_ready_i)
            ov_ff <= 1'b0;
      end
   end

   // RL13 advances once per header sent
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tid_ff <= 24'h00_0000;
      else if (ce_i && st_ff == ST_HDR && emit)
         tid_ff <= tid_ff + 24'h00_0001;
   end

   // RL9 set on spawn wins over a completion in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         live_ff <= '0;
      else if (ce_i)
         live_ff <= (live_ff & ~(done_valid_i ? (128'h1 << done_tag_i) : '0))
                    | (accept ? (128'h1 << spawn_i.tag) : '0);
   end

   assign spawn_ready_o = sp_rdy_ff;
   assign dat_ready_o   = dat_rdy_ff;
   assign out_o         = out_ff;
   assign out_valid_o   = ov_ff;

   // ==========================================================
   // Checks
   // ==========================================================
   logic hdr_out_ff;
   logic prim_out_ff;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hdr_out_ff  <= 1'b0;
         prim_out_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         hdr_out_ff  <= emit && st_ff == ST_HDR;
         prim_out_ff <= emit && st_ff == ST_PRIM;
      end
   end

   default clocking cb @(posedge clk_i iff ce_i); endclocking
   default disable iff (rst_i);

   a_ret_lower: assert property (hdr_out_ff |-> out_ff.data[15:0] == (sp_ff.ret0 & `GTPB_RET_MASK)) // RL1
      else $error("lower return offset wrong");
   a_ret_upper: assert property (hdr_out_ff |-> out_ff.data[47:32] == (sp_ff.ret1 & `GTPB_RET_MASK)) // RL2
      else $error("upper return offset wrong");
   a_inst_dual: assert property (hdr_out_ff && dual_obj |-> out_ff.data[31:27] == 5'd0 && out_ff.data[63:59] == 5'd0) // RL3
      else $error("instance number set in dual-object");
   a_topo_undef: assert property (hdr_out_ff && ctrl_ff[`GTPB_CTRL_DISC] |-> out_ff.data[85:80] == `GTPB_TOPO_UNDEF) // RL5
      else $error("topology not undefined");
   a_tag_field: assert property (hdr_out_ff |-> out_ff.data[168:160] == {2'b00, sp_ff.tag}) // RL9
      else $error("thread tag wrong");
   a_tag_live: assert property (accept |=> live_ff[$past(spawn_i.tag)] && st_ff == ST_HDR) // RL9
      else $error("tag not held after spawn");
   a_tid_step: assert property (hdr_out_ff |-> out_ff.data[215:192] == 24'(tid_ff - 24'h00_0001)) // RL13
      else $error("thread id not unique step");
   a_deref_bit: assert property (hdr_out_ff |-> out_ff.data[223] == sp_ff.deref) // RL14
      else $error("dereference flag wrong");
   a_prim_pad: assert property (prim_out_ff |-> out_ff.data[127:32] == '0 && out_ff.data[255:160] == '0) // RL16
      else $error("primitive padding not zero");
   a_prim_skip: assert property (hdr_out_ff && !inc_prim |-> st_ff != ST_PRIM) // RL15
      else $error("primitive register without enable");
   a_vtx_pair: assert property (take && st_ff == ST_VTX && dual_obj && half_ff
                                |=> out_ff.data[255:128] == $past(dat_i[127:0]) && ov_ff) // RL21
      else $error("object 1 half misplaced");

   c_dual_hdr: cover property (hdr_out_ff && dual_obj);
   c_vtx_last: cover property (ov_ff && out_ready_i && out_ff.last && $past(st_ff) == ST_VTX);
   c_tag_busy: cover property (st_ff == ST_IDLE && spawn_valid_i && sp_rdy_ff && live_ff[spawn_i.tag]);

endmodule : gtpb_payload_builder

// file: testbench/gtpb_thread_sink.sv
`timescale 1ns/1ps
// ==========================================
// Thread side: sinks beats, frees its tag late
module gtpb_thread_sink (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 slow_i,
   input  wire logic [7:0]           delay_i,
   input  wire gtpb_pkg::gtpb_beat_s beat_i,
   input  wire logic                 valid_i,
   output logic                      ready_o,
   output logic                      done_o,
   output logic [6:0]                tag_o
);
   import gtpb_pkg::*;
   gtpb_beat_s beats[$];
   int         n_done;
   logic       first_ff;
   logic       live_ff;
   logic [7:0] wait_ff;
   logic [6:0] tag_ff;
   // Random stalls when slow, so beats must be held
   always_ff @(posedge clk_i)
   begin
      ready_o <= !rst_i && (!slow_i || 1'($urandom_range(1)));
      done_o  <= 1'b0;
      if (rst_i)
      begin
         first_ff <= 1'b1;
         live_ff  <= 1'b0;
         n_done   <= 0;
      end
      else
      begin
         if (valid_i && ready_o)
         begin
            beats.push_back(beat_i);
            first_ff <= beat_i.last;
            if (first_ff)
               tag_ff <= beat_i.data[166:160];
            if (beat_i.last)
            begin
               live_ff <= 1'b1;
               wait_ff <= delay_i;
            end
         end
         if (live_ff && wait_ff == 8'h00)
         begin
            live_ff <= 1'b0;
            done_o  <= 1'b1;
            tag_o   <= tag_ff;
            n_done  <= n_done + 1;
         end
         else if (live_ff)
            wait_ff <= wait_ff - 8'h01;
      end
   end
endmodule : gtpb_thread_sink

// file: testbench/gtpb_payload_builder_tb_top.sv
`timescale 1ns/1ps
`include "gtpb_params.svh"
// ==========================================
// Bench top
module gtpb_payload_builder_tb_top;
   import gtpb_pkg::*;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         cyc = 1'b0;
   logic         stb = 1'b0;
   logic         we = 1'b0;
   logic [7:0]   adr = 8'h00;
   logic [3:0]   sel = 4'hF;
   logic [31:0]  wdat = 32'h0;
   logic [31:0]  rdat;
   logic [31:0]  wb_q;
   logic         wb_ack;
   logic         sp_v = 1'b0;
   gtpb_spawn_s  sp = '0;
   gtpb_hnd_t    hnd = '0;
   logic         sp_rdy;
   logic         dn;
   logic [6:0]   dn_tag;
   logic         dv = 1'b0;
   logic [255:0] dat = '0;
   logic         d_rdy;
   gtpb_beat_s   o;
   logic         o_v;
   logic         o_r;
   logic         slow = 1'b0;
   logic [7:0]   dly = 8'h02;
   int           n_mismatch = 0;
   int           samples_checked = 0;
   int           cycles = 0;
   logic [255:0] din[$];
   gtpb_beat_s   exp_q[$];
   logic [31:0]  r[6];
   logic [23:0]  tid = 24'h0;
   logic [5:0]   icp_si[4] = '{6'h01, 6'h08, 6'h09, 6'h20};
   logic [5:0]   icp_do[4] = '{6'h01, 6'h04, 6'h05, 6'h10};

   always #2.5 clk = ~clk;

   gtpb_payload_builder i_gtpb_payload_builder (
      .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
      .spawn_valid_i(sp_v), .spawn_i(sp), .hnd_i(hnd), .spawn_ready_o(sp_rdy),
      .done_valid_i(dn), .done_tag_i(dn_tag), .dat_valid_i(dv), .dat_i(dat), .dat_ready_o(d_rdy),
      .out_o(o), .out_valid_o(o_v), .out_ready_i(o_r));

   gtpb_thread_sink i_gtpb_thread_sink (
      .clk_i(clk), .rst_i(rst), .slow_i(slow), .delay_i(dly), .beat_i(o), .valid_i(o_v),
      .ready_o(o_r), .done_o(dn), .tag_o(dn_tag));

   task automatic test_done();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [256:0] e, input logic [256:0] s);
      samples_checked++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask : check

   // ==========================================
   // Classic bus cycle: hold until ack sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin @(posedge clk); n++; end while (wb_ack !== 1'b1 && n < 50);
      rdat = wb_q;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic cfg(input logic [1:0] m, input logic h);
      r[0] = {26'h0, 1'($urandom), 1'($urandom), h, 1'($urandom), m};
      for (int a = 1; a < 5; a++)
         r[a] = $urandom;
      r[5] = {18'h0, 6'($urandom_range(1, 2)), 2'h0, 6'($urandom_range(0, 2))};
      for (int a = 0; a < 6; a++)
         wb(1'b1, 8'(a * 4), r[a], 4'hF);
   endtask : cfg

   // ==========================================
   // Expected payload, built from the settings
   function automatic void build(input gtpb_spawn_s s, input gtpb_hnd_t h);
      gtpb_beat_s b;
      logic       dual;
      int         nc;
      dual = (r[0][1:0] == MODE_DUAL_OBJ);
      nc = int'(r[5][5:0]);
      b = '0;
      b.data[31:0] = {s.inst0, 11'h0, s.ret0 & `GTPB_RET_MASK};
      b.data[63:32] = {s.inst1, 11'h0, s.ret1 & `GTPB_RET_MASK};
      b.data[95:64] = {s.sema_idx, 1'b0, r[0][5], r[0][4] ? `GTPB_TOPO_UNDEF : s.topo, 3'h0, r[4][12:0]};
      b.data[127:96] = {r[1][31:5], 1'b0, r[3][3:0] > 4'hB ? `GTPB_SCR_SIZE_MAX : r[3][3:0]};
      b.data[159:128] = {r[2][31:5], 5'h0};
      b.data[191:160] = {r[3][31:10], 3'h0, s.tag};
      b.data[223:192] = {s.deref, 7'h0, tid};
      exp_q.push_back(b);
      tid++;
      b = '0;
      b.data[31:0] = s.prim0;
      b.data[159:128] = dual ? s.prim1 : 32'h0;
      if (r[0][2])
         exp_q.push_back(b);
      for (int j = 0; r[0][3] && j < (dual ? (s.icp_cnt + 3) / 4 : (s.icp_cnt + 7) / 8); j++)
      begin
         for (int k = 0; k < 8; k++)
            b.data[k * 32 +: 32] = dual ? h[k < 4 ? j * 4 + k : 12 + j * 4 + k] : h[j * 8 + k];
         exp_q.push_back(b);
      end
      for (int j = 0; j < nc; j++)
      begin
         b.data = din[j];
         exp_q.push_back(b);
      end
      for (int j = 0; j < s.icp_cnt * r[5][13:8]; j++)
      begin
         b.data = dual ? {din[nc + 2 * j + 1][127:0], din[nc + 2 * j][127:0]} : din[nc + j];
         exp_q.push_back(b);
      end
      exp_q[exp_q.size() - 1].last = 1'b1;
   endfunction : build

   task automatic feed(input logic [255:0] d);
      int n;
      n = 0;
      @(posedge clk);
      dv <= 1'b1;
      dat <= d;
      do begin @(posedge clk); n++; end while (d_rdy !== 1'b1 && n < 500);
      dv <= 1'b0;
      dat <= ~d;
   endtask : feed

   // Kind 1 leaves the tag live, kind 2 reuses it at once
   task automatic run(input logic [5:0] input_control_point, input logic [6:0] tg, input int kind);
      logic [159:0] rv;
      gtpb_spawn_s  s;
      gtpb_hnd_t    h;
      logic [255:0] hm;
      int           n;
      int           nd;
      rv = {$urandom, $urandom, $urandom, $urandom, $urandom};
      s = rv[$bits(gtpb_spawn_s) - 1:0];
      s.icp_cnt = input_control_point;
      s.tag = tg;
      for (int k = 0; k < 32; k++)
         h[k] = $urandom;
      din.delete();
      exp_q.delete();
      i_gtpb_thread_sink.beats.delete();
      for (int j = 0; j < r[5][5:0] + input_control_point * r[5][13:8] * (r[0][1:0] == MODE_DUAL_OBJ ? 2 : 1); j++)
         din.push_back({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
      build(s, h);
      nd = i_gtpb_thread_sink.n_done;
      n = 0;
      @(posedge clk);
      sp <= s;
      hnd <= h;
      sp_v <= 1'b1;
      do begin @(posedge clk); n++; end while (sp_rdy !== 1'b1 && n < 100);
      do begin @(posedge clk); n++; #1; end while (sp_rdy !== 1'b0 && n < 400);
      sp_v <= 1'b0;
      if (kind == 2)
         check("tag held", 257'h1, 257'(i_gtpb_thread_sink.n_done != nd));
      nd = i_gtpb_thread_sink.n_done;
      fork
         foreach (din[j]) feed(din[j]);
         for (n = 0; i_gtpb_thread_sink.beats.size() < exp_q.size() && n < 3000; n++) @(posedge clk);
      join
      check("beat count", 257'(exp_q.size()), 257'(i_gtpb_thread_sink.beats.size()));
      hm = {32'h0, 32'h80FFFFFF, 32'hFFFFFDFF, 32'hFFFFFFE0, 32'hFFFFFFEF, 32'hFF7F1FFF,
            r[0][1:0] == MODE_DUAL_OBJ ? 64'h0000FFFF_0000FFFF : 64'hF800FFFF_F800FFFF};
      foreach (exp_q[j])
      begin
         if (j >= i_gtpb_thread_sink.beats.size())
            break;
         if (j > 0)
            hm = '1;
         check("beat", {exp_q[j].last, exp_q[j].data & hm},
               {i_gtpb_thread_sink.beats[j].last, i_gtpb_thread_sink.beats[j].data & hm});
      end
      for (n = 0; kind != 1 && i_gtpb_thread_sink.n_done == nd && n < 400; n++) @(posedge clk);
   endtask : run

   // ==========================================
   // Main sequence
   initial
   begin
      void'($urandom(5973));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++)
      begin
         wb(1'b0, 8'(a * 4), 32'h0, 4'hF);
         check("reset reg", 257'h0, 257'(rdat));
      end
      wb(1'b1, 8'h10, 32'hFFFFFFFF, 4'h1);
      wb(1'b1, 8'h1C, 32'hFFFFFFFF, 4'hF);
      wb(1'b0, 8'h10, 32'h0, 4'hF);
      check("byte lane", 257'hFF, 257'(rdat));
      wb(1'b0, 8'h1C, 32'h0, 4'hF);
      check("unmapped", 257'h0, 257'(rdat));
      for (int t = 0; t < 24; t++)
      begin
         cfg(2'(t % 3), t < 12 ? 1'b1 : 1'($urandom));
         slow <= 1'($urandom);
         run(t < 12 ? (t % 3 == 2 ? icp_do[t / 3] : icp_si[t / 3])
                    : 6'($urandom_range(1, t % 3 == 2 ? 16 : 32)), 7'($urandom), 0);
      end
      cfg(MODE_SINGLE, 1'b1);
      dly <= 8'd60;
      run(6'h04, 7'h11, 1);
      run(6'h04, 7'h11, 2);
      wb(1'b0, 8'h18, 32'h0, 4'hF);
      check("status", 257'({tid, 8'h00}), 257'(rdat));
      test_done();
   end
endmodule : gtpb_payload_builder_tb_top
